//--- verilog/scsr_regs.sv
`timescale 1ns/1ps
module scsr_regs
(
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   input  wire logic        analog_saturation_i,
   input  wire logic        prox_saturation_i,
   input  wire logic        prox_threshold_i,
   input  wire logic        light_threshold_i,
   input  wire logic        calibration_done_i,
   input  wire logic        echo_saturation_i,
   input  wire logic        background_saturation_i,
   input  wire logic        results_load_i,
   input  wire logic [15:0] clear_count_i,
   input  wire logic [15:0] red_count_i,
   input  wire logic [15:0] green_count_i,
   input  wire logic [15:0] ir_count_i,
   output logic      [1:0]  prox_sensor_gain_o,
   output logic      [3:0]  prox_gain_factor_o,
   output logic      [4:0]  led_drive_level_o,
   output logic      [7:0]  led_current_ma_o,
   output logic      [1:0]  light_gain_sel_o,
   output logic      [6:0]  light_gain_factor_o,
   output logic             infrared_into_second_path_o,
   output logic      [7:0]  event_flags_o
);

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   logic [7:0]  prox_gain_drive_cfg;
   logic [7:0]  light_gain_cfg;
   logic [7:0]  misc_config_three;
   logic [15:0] clear_result;
   logic [15:0] red_result;
   logic [15:0] green_result;
   logic [7:0]  flags;
   logic [7:0]  next_rdata;
   logic [7:0]  flag_set;
   logic [7:0]  flag_w1c;
   logic [15:0] second_path_data;

   wire wr_prox_cfg  = reg_wr_i & hit(reg_addr_i, scsr_pkg::OFS_PROX_GAIN_DRIVE_CFG);
   wire wr_light_cfg = reg_wr_i & hit(reg_addr_i, scsr_pkg::OFS_LIGHT_GAIN_CFG);
   wire wr_misc_cfg  = reg_wr_i & hit(reg_addr_i, scsr_pkg::OFS_MISC_CONFIG_THREE);
   wire wr_flags     = reg_wr_i & hit(reg_addr_i, scsr_pkg::OFS_EVENT_FLAGS);
   wire rd_flags     = reg_rd_i & hit(reg_addr_i, scsr_pkg::OFS_EVENT_FLAGS);
   wire read_clear   = misc_config_three[scsr_pkg::READ_CLEAR_BIT];
   wire clr_all      = rd_flags & read_clear;

   // field extraction
   assign prox_sensor_gain_o = prox_gain_drive_cfg[scsr_pkg::PROX_GAIN_LSB +: 2];
   assign led_drive_level_o  = prox_gain_drive_cfg[scsr_pkg::LED_DRIVE_LSB +: 5];
   assign light_gain_sel_o   = light_gain_cfg[scsr_pkg::LIGHT_GAIN_LSB +: 2];
   assign infrared_into_second_path_o = light_gain_cfg[scsr_pkg::IR_PATH_BIT];
   assign event_flags_o = flags;

   // gain factors as powers of two: 2^code and 4^code
   assign prox_gain_factor_o  = 4'h1 << prox_sensor_gain_o;
   assign light_gain_factor_o = 7'h01 << {light_gain_sel_o, 1'b0};
   // 6 * (32) tops out at 192, fits eight bits
   wire logic [7:0] drive_steps = {3'h0, led_drive_level_o} + 8'h01;
   assign led_current_ma_o = 8'(scsr_pkg::LED_STEP_MA * drive_steps);

   // converter source follows the path switch at load time
   assign second_path_data = infrared_into_second_path_o ? ir_count_i : green_count_i;

   assign flag_w1c = wr_flags ? reg_wdata_i : 8'h00;

   always_comb
   begin
      flag_set = 8'h00;
      flag_set[scsr_pkg::FLAG_ANALOG_SAT]     = analog_saturation_i;
      flag_set[scsr_pkg::FLAG_PROX_SAT]       = prox_saturation_i;
      flag_set[scsr_pkg::FLAG_PROX_THRESHOLD] = prox_threshold_i;
      flag_set[scsr_pkg::FLAG_LIGHT_THRESH]   = light_threshold_i;
      flag_set[scsr_pkg::FLAG_CAL_DONE]       = calibration_done_i;
      flag_set[scsr_pkg::FLAG_ECHO_SAT]       = echo_saturation_i;
      flag_set[scsr_pkg::FLAG_BACKGROUND_SAT] = background_saturation_i;
   end

   scsr_flag_bank u_flags
   (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .set_i     (flag_set),
      .w1c_i     (flag_w1c),
      .clr_all_i (clr_all),
      .flags_o   (flags)
   );

   // read mux; unmapped offsets read as zero
   always_comb
   begin
      if (hit(reg_addr_i, scsr_pkg::OFS_PROX_GAIN_DRIVE_CFG))
         next_rdata = prox_gain_drive_cfg;
      else if (hit(reg_addr_i, scsr_pkg::OFS_LIGHT_GAIN_CFG))
         next_rdata = light_gain_cfg;
      else if (hit(reg_addr_i, scsr_pkg::OFS_REVISION_CODE))
         next_rdata = {5'h00, scsr_pkg::REVISION_NUMBER};
      else if (hit(reg_addr_i, scsr_pkg::OFS_DEVICE_TYPE_CODE))
         next_rdata = {scsr_pkg::DEVICE_TYPE, 2'h0};
      else if (hit(reg_addr_i, scsr_pkg::OFS_EVENT_FLAGS))
         next_rdata = flags; // pre-clear value is returned
      else if (hit(reg_addr_i, scsr_pkg::OFS_CLEAR_COUNT_LOW))
         next_rdata = clear_result[7:0];
      else if (hit(reg_addr_i, scsr_pkg::OFS_CLEAR_COUNT_HIGH))
         next_rdata = clear_result[15:8];
      else if (hit(reg_addr_i, scsr_pkg::OFS_RED_COUNT_LOW))
         next_rdata = red_result[7:0];
      else if (hit(reg_addr_i, scsr_pkg::OFS_RED_COUNT_HIGH))
         next_rdata = red_result[15:8];
      else if (hit(reg_addr_i, scsr_pkg::OFS_GREEN_RESULT_LOW))
         next_rdata = green_result[7:0];
      else if (hit(reg_addr_i, scsr_pkg::OFS_GREEN_RESULT_HIGH))
         next_rdata = green_result[15:8];
      else if (hit(reg_addr_i, scsr_pkg::OFS_MISC_CONFIG_THREE))
         next_rdata = misc_config_three;
      else
         next_rdata = 8'h00;
   end

   // reserved config bits are stored as plain read/write bits
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         prox_gain_drive_cfg <= scsr_pkg::RST_PROX_GAIN_DRIVE_CFG;
      else if (wr_prox_cfg)
         prox_gain_drive_cfg <= reg_wdata_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         light_gain_cfg <= scsr_pkg::RST_LIGHT_GAIN_CFG;
      else if (wr_light_cfg)
         light_gain_cfg <= reg_wdata_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         misc_config_three <= scsr_pkg::RST_MISC_CONFIG_THREE;
      else if (wr_misc_cfg)
         misc_config_three <= reg_wdata_i;
   end

   // results are captured whole so both bytes of a pair match
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         clear_result <= {scsr_pkg::RST_RESULT_BYTE, scsr_pkg::RST_RESULT_BYTE};
         red_result   <= {scsr_pkg::RST_RESULT_BYTE, scsr_pkg::RST_RESULT_BYTE};
         green_result <= {scsr_pkg::RST_RESULT_BYTE, scsr_pkg::RST_RESULT_BYTE};
      end
      else if (results_load_i)
      begin
         clear_result <= clear_count_i;
         red_result   <= red_count_i;
         green_result <= second_path_data;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
         reg_rdata_o <= next_rdata;
   end

   a_prox_gain_reset : assert property (@(posedge clk_i)
      sys_rst_i |=> (prox_sensor_gain_o == 2'h2 && led_drive_level_o == 5'h00))
      else $error("prox gain or drive wrong after reset");

   a_led_current_map : assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (led_drive_level_o == 5'h1F) |-> (led_current_ma_o == 8'hC0))
      else $error("led current for top drive is not 192");

   a_light_gain_map : assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_light_cfg && reg_wdata_i[1:0] == 2'h2 |=> light_gain_factor_o == 7'h10)
      else $error("light gain code 2 does not give 16x");

   a_event_sets_flag : assert property (@(posedge clk_i) disable iff (sys_rst_i)
      calibration_done_i |=> flags[scsr_pkg::FLAG_CAL_DONE])
      else $error("calibration event lost");

   a_saturation_sets : assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      analog_saturation_i && echo_saturation_i |=> flags[7] && flags[1])
      else $error("saturation events not flagged");

   a_w1c_clears_bit : assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_flags && reg_wdata_i[4] && !light_threshold_i |=>
      !flags[4] ##1 (!flags[4] || $past(light_threshold_i)))
      else $error("write one did not clear light flag");

   a_read_clears_all : assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_flags && read_clear && flag_set == 8'h00 |=> flags == 8'h00)
      else $error("read with read clear left flags set");

   a_read_keeps_flags : assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_flags && !read_clear && !reg_wr_i |=> flags == ($past(flags) | $past(flag_set)))
      else $error("read without read clear changed flags");

   a_status_read_data : assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_flags |=> reg_rdata_o == $past(flags))
      else $error("status read returned wrong value");

   a_ir_into_green : assert property (@(posedge clk_i) disable iff (sys_rst_i)
      results_load_i && infrared_into_second_path_o |=> green_result == $past(ir_count_i))
      else $error("green bytes did not take infrared result");

   a_clear_capture : assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      results_load_i |=> clear_result == $past(clear_count_i)
         && red_result == $past(red_count_i))
      else $error("result bytes not captured");

endmodule : scsr_regs

//--- verilog/scsr_pkg.sv
package scsr_pkg;

   // register offsets on the register port
   localparam logic [7:0] OFS_PROX_GAIN_DRIVE_CFG = 8'h8F;
   localparam logic [7:0] OFS_LIGHT_GAIN_CFG      = 8'h90;
   localparam logic [7:0] OFS_REVISION_CODE       = 8'h91;
   localparam logic [7:0] OFS_DEVICE_TYPE_CODE    = 8'h92;
   localparam logic [7:0] OFS_EVENT_FLAGS         = 8'h93;
   localparam logic [7:0] OFS_CLEAR_COUNT_LOW     = 8'h94;
   localparam logic [7:0] OFS_CLEAR_COUNT_HIGH    = 8'h95;
   localparam logic [7:0] OFS_RED_COUNT_LOW       = 8'h96;
   localparam logic [7:0] OFS_RED_COUNT_HIGH      = 8'h97;
   localparam logic [7:0] OFS_GREEN_RESULT_LOW    = 8'h98;
   localparam logic [7:0] OFS_GREEN_RESULT_HIGH   = 8'h99;
   localparam logic [7:0] OFS_MISC_CONFIG_THREE   = 8'hAB;

   // values after reset
   localparam logic [7:0] RST_PROX_GAIN_DRIVE_CFG = 8'h80;
   localparam logic [7:0] RST_LIGHT_GAIN_CFG      = 8'h00;
   localparam logic [7:0] RST_MISC_CONFIG_THREE   = 8'h00;
   localparam logic [7:0] RST_RESULT_BYTE         = 8'h00;
   localparam logic [7:0] RST_FLAGS               = 8'h00;

   // field positions
   localparam int PROX_GAIN_LSB   = 6;
   localparam int LED_DRIVE_LSB   = 0;
   localparam int IR_PATH_BIT     = 3;
   localparam int LIGHT_GAIN_LSB  = 0;
   localparam int READ_CLEAR_BIT  = 7;
   localparam int REVISION_LSB    = 0;
   localparam int DEVICE_TYPE_LSB = 2;

   // status flag positions
   localparam int FLAG_ANALOG_SAT     = 7;
   localparam int FLAG_PROX_SAT       = 6;
   localparam int FLAG_PROX_THRESHOLD = 5;
   localparam int FLAG_LIGHT_THRESH   = 4;
   localparam int FLAG_CAL_DONE       = 3;
   localparam int FLAG_ECHO_SAT       = 1;
   localparam int FLAG_BACKGROUND_SAT = 0;

   // led current step in milliamps
   localparam logic [7:0] LED_STEP_MA = 8'h06;

   // identity codes, values arbitrary
   localparam logic [2:0] REVISION_NUMBER  = 3'h1;
   localparam logic [5:0] DEVICE_TYPE      = 6'h15;

endpackage : scsr_pkg

//--- verilog/scsr_flag_bank.sv
`timescale 1ns/1ps
module scsr_flag_bank
(
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic [7:0] set_i,
   input  wire logic [7:0] w1c_i,
   input  wire logic       clr_all_i,
   output logic      [7:0] flags_o
);
   wire logic [7:0] next_flags;

   genvar k;
   generate
      for (k = 0; k < 8; k = k + 1)
      begin : g_flag
         // set wins so an event in the clearing cycle is kept
         wire logic clear_bit = w1c_i[k] | clr_all_i;
         assign next_flags[k] = set_i[k] | (flags_o[k] & ~clear_bit);
      end
   endgenerate

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         flags_o <= scsr_pkg::RST_FLAGS;
      else
         flags_o <= next_flags;
   end

   a_flag_sticky_hold : assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (set_i == 8'h00 && w1c_i == 8'h00 && !clr_all_i) |=> flags_o == $past(flags_o))
      else $error("status flag changed without cause");

endmodule : scsr_flag_bank

//--- test/scsr_host_model.sv
`timescale 1ns/1ps
module scsr_host_model
(
   input  wire logic       clk_i,
   input  wire logic [7:0] reg_rdata_i,
   output logic      [7:0] reg_addr_o,
   output logic            reg_wr_o,
   output logic      [7:0] reg_wdata_o,
   output logic            reg_rd_o
);
   initial
   begin
      reg_addr_o  = 8'h00;
      reg_wr_o    = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o    = 1'b0;
   end

   // one strobe per byte; lines scrambled after release so stale data never helps
   task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge clk_i);
      #1;
      reg_addr_o  = a;
      reg_wdata_o = d;
      reg_wr_o    = w;
      reg_rd_o    = !w;
      @(posedge clk_i);
      #1;
      q           = reg_rdata_i;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_addr_o  = ~a;
      reg_wdata_o = ~d;
   endtask : xfer
endmodule : scsr_host_model

//--- test/scsr_regs_bench.sv
`timescale 1ns/1ps
module scsr_regs_bench;
   localparam logic [7:0] PG = scsr_pkg::OFS_PROX_GAIN_DRIVE_CFG;
   localparam logic [7:0] LG = scsr_pkg::OFS_LIGHT_GAIN_CFG;
   localparam logic [7:0] FL = scsr_pkg::OFS_EVENT_FLAGS;
   localparam logic [7:0] MC = scsr_pkg::OFS_MISC_CONFIG_THREE;
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, event_flags_o, led_current_ma_o;
   logic        reg_wr_i, reg_rd_i, results_load_i = 1'b0, infrared_into_second_path_o;
   logic [7:0]  ev = 8'h00;
   logic [15:0] clear_count_i = 16'h0, red_count_i = 16'h0;
   logic [15:0] green_count_i = 16'h0, ir_count_i = 16'h0;
   logic [1:0]  prox_sensor_gain_o, light_gain_sel_o;
   logic [3:0]  prox_gain_factor_o;
   logic [4:0]  led_drive_level_o;
   logic [6:0]  light_gain_factor_o;
   int          errors = 0;
   int          total_checks = 0;

   always #12.5 clk_i = ~clk_i;

   scsr_regs u_scsr_regs
   (
      .clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
      .analog_saturation_i(ev[7]), .prox_saturation_i(ev[6]), .prox_threshold_i(ev[5]),
      .light_threshold_i(ev[4]), .calibration_done_i(ev[3]), .echo_saturation_i(ev[1]),
      .background_saturation_i(ev[0]), .results_load_i, .clear_count_i, .red_count_i,
      .green_count_i, .ir_count_i, .prox_sensor_gain_o, .prox_gain_factor_o,
      .led_drive_level_o, .led_current_ma_o, .light_gain_sel_o, .light_gain_factor_o,
      .infrared_into_second_path_o, .event_flags_o
   );

   scsr_host_model u_scsr_host_model
   (
      .clk_i, .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
      .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_scsr_host_model.xfer(a, 1'b1, d, q);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      u_scsr_host_model.xfer(a, 1'b0, 8'h00, q);
      check(q, exp);
   endtask : rd_chk

   task automatic pulse(input logic [7:0] v);
      @(posedge clk_i);
      #1;
      ev = v;
      @(posedge clk_i);
      #1;
      ev = 8'h00;
   endtask : pulse

   // inputs flipped after capture, so only a held copy can match
   task automatic load(input logic [15:0] c, r, g, i);
      @(posedge clk_i);
      #1;
      {clear_count_i, red_count_i, green_count_i, ir_count_i} = {c, r, g, i};
      results_load_i = 1'b1;
      @(posedge clk_i);
      #1;
      results_load_i = 1'b0;
      {clear_count_i, red_count_i, green_count_i, ir_count_i} = ~{c, r, g, i};
   endtask : load

   task automatic t_reset;
      rd_chk(PG, 8'h80);
      check(8'(prox_gain_factor_o), 8'h04);
      check(led_current_ma_o, 8'h06);
      rd_chk(LG, 8'h00);
      check(8'(light_gain_factor_o), 8'h01);
      rd_chk(FL, 8'h00);
      rd_chk(8'h94, 8'h00);
      rd_chk(8'h95, 8'h00);
      rd_chk(8'h96, 8'h00);
      rd_chk(MC, 8'h00);
   endtask : t_reset

   task automatic t_fields;
      for (int g = 0; g < 4; g++)
      begin
         wr(PG, {g[1:0], 1'b1, 5'h1F});
         check({6'h00, prox_sensor_gain_o}, {6'h00, g[1:0]});
         check(8'(prox_gain_factor_o), 8'h01 << g);
         check({3'h0, led_drive_level_o}, 8'h1F);
         check(led_current_ma_o, 8'hC0);
         wr(LG, {6'h00, g[1:0]});
         check({6'h00, light_gain_sel_o}, {6'h00, g[1:0]});
         check(8'(light_gain_factor_o), 8'h01 << (2 * g));
      end
      wr(PG, 8'h01);
      check(led_current_ma_o, 8'h0C);
      rd_chk(PG, 8'h01);
   endtask : t_fields

   // raise one event, prove it sticks through a write with its own bit zero, then clear it
   task automatic flag_cycle(input int b);
      pulse(8'h01 << b);
      check(event_flags_o, 8'h01 << b);
      wr(FL, ~(8'h01 << b));
      rd_chk(FL, 8'h01 << b);
      wr(FL, 8'h01 << b);
      check(event_flags_o, 8'h00);
   endtask : flag_cycle

   task automatic t_flags;
      flag_cycle(7);
      flag_cycle(6);
      flag_cycle(5);
      flag_cycle(4);
      flag_cycle(3);
      flag_cycle(1);
      flag_cycle(0);
   endtask : t_flags

   task automatic t_read_clear;
      pulse(8'hFB);
      wr(MC, 8'h80);
      rd_chk(MC, 8'h80);
      rd_chk(FL, 8'hFB);
      check(event_flags_o, 8'h00);
      wr(MC, 8'h00);
   endtask : t_read_clear

   task automatic t_results;
      load(16'h1234, 16'hABCD, 16'h5566, 16'h7788);
      rd_chk(8'h94, 8'h34);
      rd_chk(8'h95, 8'h12);
      rd_chk(8'h96, 8'hCD);
      rd_chk(8'h97, 8'hAB);
      wr(8'h94, 8'hEE);
      rd_chk(8'h94, 8'h34);
      rd_chk(8'h98, 8'h66);
      wr(LG, 8'h08);
      check(8'(infrared_into_second_path_o), 8'h01);
      load(16'h1234, 16'hABCD, 16'h5566, 16'h7788);
      rd_chk(8'h98, 8'h88);
      rd_chk(8'h99, 8'h77);
      rd_chk(8'h00, 8'h00);
      rd_chk(8'h91, {5'h00, scsr_pkg::REVISION_NUMBER});
      rd_chk(8'h92, {scsr_pkg::DEVICE_TYPE, 2'b00});
   endtask : t_results

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   // whole run is about 144 cycles; the 5000 cycle limit leaves ample margin
   initial
   begin
      #(25 * 5000);
      errors++;
      results();
   end

   initial
   begin
      repeat (12) @(posedge clk_i);
      #1;
      sys_rst_i = 1'b0;
      t_reset();
      t_fields();
      t_flags();
      t_read_clear();
      t_results();
      results();
   end
endmodule : scsr_regs_bench
